/* File: shared/tws_cfg.svh */
// Constants of the two-wire memory slave
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// ---------------------------------------------------------------
// Array geometry
// ---------------------------------------------------------------
`define TWS_ADDR_W      15
`define TWS_DATA_W      8
`define TWS_MEM_DEPTH   32768
`define TWS_ADDR_ZERO   15'h0000
`define TWS_ADDR_STEP   15'h0001

// ---------------------------------------------------------------
// Slave address byte fields
// ---------------------------------------------------------------
`define TWS_SA_TYPE_HI  7
`define TWS_SA_TYPE_LO  4
`define TWS_SA_SEL_HI   3
`define TWS_SA_SEL_LO   1
`define TWS_SA_RW_BIT   0

// ---------------------------------------------------------------
// Byte framing and buffering
// ---------------------------------------------------------------
`define TWS_BIT_LAST    4'h7
`define TWS_BIT_ACK     4'h8
`define TWS_BIT_FIRST   4'h1
`define TWS_BIT_RESET   4'h0
`define TWS_FIFO_DEPTH  4

`endif

/* File: shared/tws_pkg.sv */
// Types shared by the two-wire memory slave modules
`include "tws_cfg.svh"

package tws_pkg;

   typedef enum {
      ST_IDLE,
      ST_SADDR,
      ST_AHI,
      ST_ALO,
      ST_WDATA,
      ST_RDATA
   } tws_state_e;

   typedef struct packed {
      logic [`TWS_ADDR_W-1:0] addr;
      logic [`TWS_DATA_W-1:0] data;
   } tws_wr_rec_s;

endpackage

/* File: src/tws_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module tws_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output var  logic [W-1:0] o_q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         o_q    <= '0;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end

endmodule

`default_nettype wire

/* File: src/tws_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"

module tws_fifo #(
   parameter int W     = 23,
   parameter int DEPTH = `TWS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // Fill side
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   // Drain side
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   count_r;
   logic          push;
   logic          pop;

   assign o_ready = (count_r != (AW+1)'(DEPTH));
   assign o_valid = (count_r != '0);
   assign o_data  = mem_r[rd_ptr_r];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      wrap_inc = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wrap_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= wrap_inc(rd_ptr_r);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

/* File: src/tws_nvmem_slave.sv */
// Two-wire serial slave in front of a byte-wide nonvolatile array
//
// Overview of operation
// - Answer only when the address select bits equal the three select pins.
// - Protect input high blocks every array write; low allows all writes.
// - Open protect input reads low through the pad pull-down: writable.
// - Data line is only pulled low or released, never driven high.
// - Transmitted bits change only after a falling clock edge.
// - Received bits are sampled on the rising clock edge.
// - Array holds 32768 bytes, each readable and writable serially.
// - Word address is 16 bits; its top bit is ignored.
// - Writes finish inside the transfer; device never reports busy.
// - Only the power-on reset initialises the interface logic.
// - First byte: type in 7-4, select in 3-1, direction in 0.
// - Address advances after each data byte before acknowledge, wraps to zero.
// - A start condition anywhere aborts and awaits a slave address.
`timescale 1ns/1ps
`default_nettype none
`include "tws_cfg.svh"

module tws_nvmem_slave
   import tws_pkg::*;
#(
   parameter logic [3:0] P_TYPE_ID = 4'h5  // Arbitrary device type value
) (
   // Core clock and power-on reset
   input  wire logic               i_core_clk,
   input  wire logic               i_rst_n,
   // Serial bus
   input  wire logic               i_scl,
   input  wire logic               i_sda,
   output logic                    o_sda_o,
   output logic                    o_sda_oe,
   // Straps
   input  wire logic [2:0]         i_device_select_pins,
   input  wire logic               i_wp,
   // Write monitor stream
   output logic                    o_mon_valid,
   output tws_pkg::tws_wr_rec_s    o_mon_rec,
   input  wire logic               i_mon_ready,
   output logic                    o_mon_overrun
);
   import tws_pkg::*;

   // ------------------------------------------------------------
   // Link-side state (clocked by the bus clock)
   // ------------------------------------------------------------
   logic [`TWS_DATA_W-1:0] mem_r [`TWS_MEM_DEPTH];
   tws_state_e             state_r;
   logic [3:0]             cnt_r;
   logic [7:0]             shift_r;
   logic [7:0]             rd_byte_r;
   logic [`TWS_ADDR_W-1:0] addr_r;
   logic [6:0]             addr_hi_r;
   logic                   ack_pend_r;
   logic                   sda_oe_r;
   logic                   sda_o_r;
   logic                   start_tgl_r;
   logic                   stop_tgl_r;
   logic                   start_seen_r;
   logic                   stop_seen_r;
   logic                   req_r;
   logic                   overrun_r;
   tws_wr_rec_s            hold_r;
   logic [3:0]             strap_s;
   logic                   ack_s;
   logic [7:0]             rx_byte;
   logic                   start_hit;
   logic                   stop_hit;
   logic                   sel_match;
   logic                   mem_we;
   logic                   wp_s;
   logic [2:0]             sel_s;

   // ------------------------------------------------------------
   // Core-side state
   // ------------------------------------------------------------
   logic [1:0]             core_s;
   logic                   req_s;
   logic                   ack_r;
   logic                   ev_valid;
   logic                   fifo_in_ready;
   logic                   fifo_out_valid;
   logic                   fifo_pop;
   tws_wr_rec_s            fifo_out;
   logic                   mon_valid_r;
   tws_wr_rec_s            mon_rec_r;

   function automatic logic [`TWS_ADDR_W-1:0] next_addr(
      input logic [`TWS_ADDR_W-1:0] a
   );
      next_addr = a + `TWS_ADDR_STEP;  // 7fff rolls to 0000
   endfunction

   assign rx_byte   = {shift_r[6:0], i_sda};
   assign start_hit = (start_tgl_r != start_seen_r);
   assign stop_hit  = (stop_tgl_r != stop_seen_r);
   assign wp_s      = strap_s[3];
   assign sel_s     = strap_s[2:0];
   assign sel_match =
      (rx_byte[`TWS_SA_TYPE_HI:`TWS_SA_TYPE_LO] == P_TYPE_ID) &&
      (rx_byte[`TWS_SA_SEL_HI:`TWS_SA_SEL_LO] == sel_s);
   // Pad pull-down makes a floating pin read 0, so only high protects
   assign mem_we    = (state_r == ST_WDATA) && (cnt_r == `TWS_BIT_LAST) &&
                      !start_hit && !stop_hit && !wp_s;

   // ------------------------------------------------------------
   // Start and stop detection
   // ------------------------------------------------------------
   // Toggles flip while the clock is high; they are settled for the
   // whole low phase before the next rising edge reads them.
   always_ff @(negedge i_sda or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_tgl_r <= 1'b0;
      end else if (i_scl) begin
         start_tgl_r <= ~start_tgl_r;
      end
   end

   always_ff @(posedge i_sda or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stop_tgl_r <= 1'b0;
      end else if (i_scl) begin
         stop_tgl_r <= ~stop_tgl_r;
      end
   end

   always_ff @(posedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_seen_r <= 1'b0;
         stop_seen_r  <= 1'b0;
      end else begin
         start_seen_r <= start_tgl_r;
         stop_seen_r  <= stop_tgl_r;
      end
   end

   tws_sync #(.W(4)) u_strap_sync (
      .i_clk   (i_scl),
      .i_rst_n (i_rst_n),
      .i_d     ({i_wp, i_device_select_pins}),
      .o_q     (strap_s)
   );

   // ------------------------------------------------------------
   // Receive shifter
   // ------------------------------------------------------------
   always_ff @(posedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_r <= 8'h00;
      end else begin
         shift_r <= rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r    <= ST_IDLE;
         cnt_r      <= `TWS_BIT_RESET;
         ack_pend_r <= 1'b0;
         addr_r     <= `TWS_ADDR_ZERO;
         addr_hi_r  <= 7'h00;
         rd_byte_r  <= 8'h00;
      end else if (start_hit) begin
         state_r    <= ST_SADDR;
         cnt_r      <= `TWS_BIT_FIRST;
         ack_pend_r <= 1'b0;
      end else if (stop_hit || state_r == ST_IDLE) begin
         state_r    <= ST_IDLE;
         cnt_r      <= `TWS_BIT_RESET;
         ack_pend_r <= 1'b0;
      end else if (cnt_r == `TWS_BIT_ACK) begin
         cnt_r      <= `TWS_BIT_RESET;
         ack_pend_r <= 1'b0;
         if (state_r == ST_RDATA) begin
            if (i_sda) begin
               state_r <= ST_IDLE;
            end else begin
               rd_byte_r <= mem_r[addr_r];
            end
         end
      end else begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == `TWS_BIT_LAST) begin
            case (state_r)
               ST_SADDR: begin
                  if (sel_match) begin
                     ack_pend_r <= 1'b1;
                     if (rx_byte[`TWS_SA_RW_BIT]) begin
                        state_r   <= ST_RDATA;
                        rd_byte_r <= mem_r[addr_r];
                     end else begin
                        state_r <= ST_AHI;
                     end
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
               ST_AHI: begin
                  addr_hi_r  <= rx_byte[6:0];
                  ack_pend_r <= 1'b1;
                  state_r    <= ST_ALO;
               end
               ST_ALO: begin
                  addr_r     <= {addr_hi_r, rx_byte};
                  ack_pend_r <= 1'b1;
                  state_r    <= ST_WDATA;
               end
               ST_WDATA: begin
                  addr_r     <= next_addr(addr_r);
                  ack_pend_r <= 1'b1;
               end
               ST_RDATA: begin
                  addr_r <= next_addr(addr_r);
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Array: the write lands on the 8th rising edge, before the ack
   // ------------------------------------------------------------
   always_ff @(posedge i_scl) begin
      if (mem_we) begin
         mem_r[addr_r] <= rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Data line driver: pull low or release only
   // ------------------------------------------------------------
   always_ff @(negedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sda_oe_r <= 1'b0;
      end else if (state_r == ST_IDLE) begin
         sda_oe_r <= 1'b0;
      end else if (cnt_r == `TWS_BIT_ACK) begin
         sda_oe_r <= ack_pend_r;
      end else if (state_r == ST_RDATA) begin
         sda_oe_r <= ~rd_byte_r[3'h7 - cnt_r[2:0]];
      end else begin
         sda_oe_r <= 1'b0;
      end
   end

   always_ff @(negedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sda_o_r <= 1'b0;
      end else begin
         sda_o_r <= 1'b0;
      end
   end

   assign o_sda_oe = sda_oe_r;
   assign o_sda_o  = sda_o_r;

   // ------------------------------------------------------------
   // Write event hand-off to the core domain
   // ------------------------------------------------------------
   // The bus cannot be stalled, so a write arriving while the last one
   // is still unacknowledged is dropped from the monitor and flagged.
   always_ff @(posedge i_scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_r     <= 1'b0;
         overrun_r <= 1'b0;
         hold_r    <= '0;
      end else if (mem_we) begin
         if (req_r == ack_s) begin
            hold_r <= '{addr: addr_r, data: rx_byte};
            req_r  <= ~req_r;
         end else begin
            overrun_r <= 1'b1;
         end
      end
   end

   tws_sync #(.W(1)) u_ack_sync (
      .i_clk   (i_scl),
      .i_rst_n (i_rst_n),
      .i_d     (ack_r),
      .o_q     (ack_s)
   );

   tws_sync #(.W(2)) u_core_sync (
      .i_clk   (i_core_clk),
      .i_rst_n (i_rst_n),
      .i_d     ({overrun_r, req_r}),
      .o_q     (core_s)
   );

   assign req_s    = core_s[0];
   assign ev_valid = (req_s != ack_r);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
      end else if (ev_valid && fifo_in_ready) begin
         ack_r <= ~ack_r;
      end
   end

   tws_fifo #(.W($bits(tws_wr_rec_s)), .DEPTH(`TWS_FIFO_DEPTH)) u_fifo (
      .i_clk   (i_core_clk),
      .i_rst_n (i_rst_n),
      .i_valid (ev_valid),
      .o_ready (fifo_in_ready),
      .i_data  (hold_r),
      .o_valid (fifo_out_valid),
      .i_ready (fifo_pop),
      .o_data  (fifo_out)
   );

   // ------------------------------------------------------------
   // Registered monitor output stage
   // ------------------------------------------------------------
   assign fifo_pop = fifo_out_valid && (!mon_valid_r || i_mon_ready);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mon_valid_r <= 1'b0;
         mon_rec_r   <= '0;
      end else if (!mon_valid_r || i_mon_ready) begin
         mon_valid_r <= fifo_out_valid;
         if (fifo_out_valid) begin
            mon_rec_r <= fifo_out;
         end
      end
   end

   assign o_mon_valid   = mon_valid_r;
   assign o_mon_rec     = mon_rec_r;
   assign o_mon_overrun = core_s[1];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_rd_last;
      state_r == ST_RDATA && cnt_r == `TWS_BIT_LAST && !start_hit && !stop_hit;
   endsequence

   sequence s_master_ack;
      cnt_r == `TWS_BIT_ACK && !i_sda && !start_hit && !stop_hit;
   endsequence

   a_sel_mismatch: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_r == ST_SADDR && cnt_r == `TWS_BIT_LAST && !start_hit &&
       !stop_hit && rx_byte[3:1] != sel_s) |=> !ack_pend_r && state_r == ST_IDLE)
      else $error("Select mismatch was acknowledged");

   a_wp_no_event: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_r == ST_WDATA && cnt_r == `TWS_BIT_LAST && wp_s) |=> $stable(req_r)
      && $stable(overrun_r))
      else $error("Protected write reached the array");

   a_release_idle: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_r == ST_IDLE && $past(state_r) == ST_IDLE) |-> !sda_oe_r)
      else $error("Data line held while idle");

   a_drive_window: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      sda_oe_r |-> (cnt_r == `TWS_BIT_ACK || state_r == ST_RDATA))
      else $error("Data line pulled outside ack or read");

   a_addr_wrap: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_r == ST_WDATA && cnt_r == `TWS_BIT_LAST && !start_hit && !stop_hit)
      |=> addr_r == $past(addr_r) + `TWS_ADDR_STEP)
      else $error("Address did not advance after data byte");

   a_addr_msb: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      (state_r == ST_ALO && cnt_r == `TWS_BIT_LAST && !start_hit && !stop_hit)
      |=> addr_r[14:8] == $past(addr_hi_r) && addr_r[7:0] == $past(rx_byte))
      else $error("Word address not loaded from low 15 bits");

   a_start_abort: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      start_hit |=> state_r == ST_SADDR && cnt_r == `TWS_BIT_FIRST)
      else $error("Start did not restart address phase");

   a_rx_sample: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      1'b1 |=> shift_r[0] == $past(i_sda))
      else $error("Received bit not taken on rising edge");

   a_read_next: assert property (@(posedge i_scl) disable iff (!i_rst_n)
      s_rd_last ##1 s_master_ack |=> state_r == ST_RDATA && cnt_r == 4'h0)
      else $error("Read did not continue after master ack");

   a_ev_push: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (ev_valid && fifo_in_ready) |=> !ev_valid ##1 !ev_valid)
      else $error("Write event not taken by the buffer");

endmodule

`default_nettype wire

/* File: verif/tws_master_model.sv */
// Behavioural two-wire bus master that faces the memory slave
`timescale 1ns/1ps
`default_nettype none

module tws_master_model #(
   parameter logic [3:0] P_ID = 4'h5
) (
   // Bus wires
   output logic      o_scl,
   output logic      o_sda_oe,
   input  wire logic i_sda
);
   // ------------------------------------------------------------
   // Bit and byte cycles
   // ------------------------------------------------------------
   // Clock stands high between frames; one bit every 64 ns
   localparam time Q = 16ns;

   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   task automatic start_cond();
      o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b1;
      #Q o_scl = 1'b0;
      #Q;
   endtask

   task automatic stop_cond();
      o_sda_oe = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b0;
      #(2*Q);
   endtask

   // Data only moves while the clock is low
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         o_sda_oe = ~b[7-i];
         #Q o_scl = 1'b1;
         #(2*Q) o_scl = 1'b0;
         #Q;
      end
   endtask

   // Released wire: pull-up gives high unless the slave pulls it
   task automatic clk_in(output logic v);
      o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
      #Q v = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask

   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic v;
      send_bits(b, 8);
      clk_in(v);
      ack = ~v;
   endtask

   task automatic read_byte(input logic mack, output logic [7:0] d);
      logic v;
      for (int i = 0; i < 8; i++) begin
         clk_in(v);
         d = {d[6:0], v};
      end
      send_bits({~mack, 7'h00}, 1);
   endtask

   task automatic set_addr(input logic [2:0] sel, input logic [15:0] a,
                           output logic ok);
      logic a0, a1, a2;
      start_cond();
      write_byte({P_ID, sel, 1'b0}, a0);
      write_byte(a[15:8], a1);
      write_byte(a[7:0], a2);
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_tws_nvmem_slave.sv */
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none

module tb_tws_nvmem_slave;
   import tws_pkg::*;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   localparam logic [3:0] ID  = 4'h5;
   localparam logic [2:0] SEL = 3'h5;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n    = 1'b0;
   logic        wp         = 1'b0;  // Open pad reads low
   logic        mon_ready  = 1'b1;
   logic        scl, m_oe, sda, sda_o, sda_oe, mon_valid, overrun;
   tws_wr_rec_s mon_rec;
   tws_wr_rec_s recs[$];
   int          failures   = 0;
   int          compares   = 0;

   always #10 i_core_clk = ~i_core_clk;
   // Wired-AND with external pull-up
   assign sda = ~(m_oe | (sda_oe & ~sda_o));

   tws_nvmem_slave #(.P_TYPE_ID(ID)) i_tws_nvmem_slave (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .i_device_select_pins(SEL), .i_wp(wp),
      .o_mon_valid(mon_valid), .o_mon_rec(mon_rec),
      .i_mon_ready(mon_ready), .o_mon_overrun(overrun));

   tws_master_model #(.P_ID(ID)) i_tws_master_model (
      .o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

   always @(posedge i_core_clk) begin
      if (mon_valid === 1'b1 && mon_ready === 1'b1) begin
         recs.push_back(mon_rec);
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic stop_test();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic core_wait(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask

   // Bounded wait: records may lag the bus by a few core cycles
   task automatic get_rec(input logic [14:0] a, input logic [7:0] d);
      tws_wr_rec_s r;
      for (int i = 0; i < 60 && recs.size() == 0; i++) begin
         @(posedge i_core_clk);
      end
      if (recs.size() == 0) begin
         failures++;
         $display("wrong value at %0t: no write record", $time);
         stop_test();
      end else begin
         r = recs.pop_front();
         check({1'b0, r.addr}, {1'b0, a});
         check({8'h00, r.data}, {8'h00, d});
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d0,
                     input int n);
      logic ok, ack;
      i_tws_master_model.set_addr(SEL, a, ok);
      check(ok, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_tws_master_model.write_byte(d0 + 8'(i), ack);
         check(ack, 1'b1);
      end
      i_tws_master_model.stop_cond();
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] d0);
      logic ok, ack;
      logic [7:0] d;
      i_tws_master_model.set_addr(SEL, a, ok);
      i_tws_master_model.start_cond();
      i_tws_master_model.write_byte({ID, SEL, 1'b1}, ack);
      check({ok, ack}, 2'b11);
      i_tws_master_model.read_byte(1'b1, d);
      check(d, d0);
      i_tws_master_model.read_byte(1'b0, d);
      check(d, d0 + 8'h01);
      i_tws_master_model.stop_cond();
      check(sda_oe, 1'b0);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_select();
      logic ack;
      for (int s = 0; s < 8; s++) begin
         i_tws_master_model.start_cond();
         i_tws_master_model.write_byte({ID, 3'(s), 1'b0}, ack);
         check(ack, 1'(s == SEL));
         i_tws_master_model.stop_cond();
      end
   endtask

   task automatic t_write();
      wr(16'h8123, 8'h3c, 2);
      get_rec(15'h0123, 8'h3c);
      get_rec(15'h0124, 8'h3d);
      check(sda_o, 1'b0);
      rd(16'h0123, 8'h3c);
   endtask

   task automatic t_protect();
      @(posedge i_core_clk) wp <= 1'b1;
      wr(16'h0123, 8'h55, 2);
      core_wait(60);
      check(16'(recs.size()), 16'h0000);
      @(posedge i_core_clk) wp <= 1'b0;
      rd(16'h0123, 8'h3c);
   endtask

   task automatic t_wrap();
      wr(16'h7fff, 8'ha1, 2);
      get_rec(15'h7fff, 8'ha1);
      get_rec(15'h0000, 8'ha2);
      rd(16'h7fff, 8'ha1);
   endtask

   // Start after half a data byte must leave the array alone
   task automatic t_abort();
      logic ok;
      i_tws_master_model.set_addr(SEL, 16'h0124, ok);
      i_tws_master_model.send_bits(8'hff, 4);
      i_tws_master_model.start_cond();
      i_tws_master_model.stop_cond();
      core_wait(60);
      check(16'(recs.size()), 16'h0000);
      rd(16'h0123, 8'h3c);
   endtask

   // Sink stalls: buffer fills, records drop, array still written
   task automatic t_stall();
      @(posedge i_core_clk) mon_ready <= 1'b0;
      wr(16'h0200, 8'h10, 12);
      check(overrun, 1'b1);
      check(mon_valid, 1'b1);
      @(posedge i_core_clk) mon_ready <= 1'b1;
      get_rec(15'h0200, 8'h10);
      core_wait(60);
      check(mon_valid, 1'b0);
      recs.delete();
      rd(16'h020a, 8'h1a);
   endtask

   initial begin
      repeat (12) @(posedge i_core_clk);
      check({sda_oe, mon_valid, overrun}, 3'b000);
      i_rst_n <= 1'b1;
      core_wait(4);
      t_select();
      t_write();
      t_protect();
      t_wrap();
      t_abort();
      t_stall();
      stop_test();
   end
endmodule
`default_nettype wire
